// >>> src/start_ctrl_pkg.sv
// Constants and types shared by the start source and current limit block.
// Assumes a single 50 MHz system clock and an APB register port.
package start_ctrl_pkg;
    // ======================================================
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1_000;
    localparam int TICK_MS = 1;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S * TICK_MS;
    // ======================================================
    // Widths
    localparam int ADDR_W = 8;
    localparam int CUR_W = 10;
    localparam int SEC_W = 9;
    localparam int MS_W = 19;
    // ======================================================
    // Command source codes
    localparam logic [1:0] SRC_KEYPAD = 2'h0;
    localparam logic [1:0] SRC_TERMINAL = 2'h1;
    localparam logic [1:0] SRC_SERIAL = 2'h2;
    // ======================================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_LOCAL_SRC = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_REMOTE_SRC = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_INIT_CUR = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MAX_CUR = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_RAMP_TIME = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_UTS_TIME = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_CUR_REF = 8'h20;
    // ======================================================
    // Field positions
    localparam int CTRL_REMOTE_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_STOP_BIT = 2;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_SRC_LSB = 4;
    localparam int STAT_REMOTE_BIT = 8;
    localparam int STAT_UTS_BIT = 9;
    // ======================================================
    // Reset values and limits
    localparam logic [1:0] SRC_RST = SRC_TERMINAL;
    localparam logic [CUR_W-1:0] INIT_CUR_RST = 10'h064;
    localparam logic [CUR_W-1:0] INIT_CUR_MIN = 10'h032;
    localparam logic [CUR_W-1:0] INIT_CUR_MAX = 10'h258;
    localparam logic [CUR_W-1:0] MAX_CUR_RST = 10'h258;
    localparam logic [CUR_W-1:0] MAX_CUR_MIN = 10'h064;
    localparam logic [CUR_W-1:0] MAX_CUR_MAX = 10'h320;
    localparam logic [SEC_W-1:0] RAMP_TIME_RST = 9'h00F;
    localparam logic [SEC_W-1:0] RAMP_TIME_MAX = 9'h12C;
    localparam logic [SEC_W-1:0] UTS_TIME_RST = 9'h014;
    localparam logic [SEC_W-1:0] UTS_TIME_MIN = 9'h001;
    localparam logic [SEC_W-1:0] UTS_TIME_MAX = 9'h12C;
    // ======================================================
    // Motor start sequence
    typedef enum logic [1:0] {ST_IDLE, ST_RAMP, ST_HOLD, ST_RUN} motor_state_t;

    // Inclusive range check for a written value
    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction
endpackage

// >>> src/tick_gen.sv
// Enable divider: one-cycle tick every DIV enabled cycles.
// Assumes the enable and clear are synchronous to the clock.
`timescale 1ns/1ps
module tick_gen #(
    parameter int DIV = 50_000
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic clr,
    input wire logic en,
    output logic tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    // ======================================================
    // Parameter check
    initial begin
        if (DIV < 1) begin
            $error("tick_gen: DIV must be at least 1");
        end
    end

    logic [CW-1:0] cnt_r;
    wire atLast = (cnt_r == LAST);

    // Count enabled cycles, wrap at the last one
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cnt_r <= '0;
        end else if (clr) begin
            cnt_r <= '0;
        end else if (en) begin
            cnt_r <= atLast ? '0 : cnt_r + 1'b1;
        end
    end

    assign tick = en && atLast && !clr;
endmodule

// >>> src/ramp_gen.sv
// Linear current ramp from an initial to a final level over a time in ms.
// Assumes one tick per millisecond and a load pulse at each start.
`timescale 1ns/1ps
module ramp_gen #(
    parameter int LVL_W = 10,
    parameter int MSW = 19
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic load,
    input wire logic tick,
    input wire logic [LVL_W-1:0] initLvl,
    input wire logic [LVL_W-1:0] maxLvl,
    input wire logic [MSW-1:0] rampMs,
    output logic [LVL_W-1:0] level,
    output logic done
);
    // ======================================================
    // Parameter check
    initial begin
        if (LVL_W >= MSW) begin
            $error("ramp_gen: level width must be below time width");
        end
    end

    logic [LVL_W-1:0] level_r;
    logic [MSW-1:0] elapsed_r;
    logic [MSW:0] acc_r;
    logic done_r;

    // Step size and error accumulator (one step at most per tick)
    wire [LVL_W-1:0] delta = (maxLvl > initLvl) ? maxLvl - initLvl : '0;
    wire [MSW:0] accSum = acc_r + (MSW + 1)'(delta);
    wire stepUp = accSum >= {1'b0, rampMs};
    wire [MSW-1:0] elapsedNxt = elapsed_r + 1'b1;

    // Ramp progress, ends exactly on the final level
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            level_r <= '0;
            elapsed_r <= '0;
            acc_r <= '0;
            done_r <= 1'b0;
        end else if (load) begin
            level_r <= (rampMs == '0) ? maxLvl : initLvl;
            elapsed_r <= '0;
            acc_r <= '0;
            done_r <= (rampMs == '0);
        end else if (tick && !done_r) begin
            elapsed_r <= elapsedNxt;
            acc_r <= stepUp ? accSum - {1'b0, rampMs} : accSum;
            if (elapsedNxt == rampMs) begin
                level_r <= maxLvl;
                done_r <= 1'b1;
            end else if (stepUp) begin
                level_r <= level_r + 1'b1;
            end
        end
    end

    assign level = level_r;
    assign done = done_r;
endmodule

// >>> src/start_source_current.sv
// Start/stop source selection and motor start current ramp, APB registers.
// Assumes a 50 MHz clock, synchronous inputs and a zero-wait APB master.
// Operation
// R1: Source settings hold keypad, terminal or serial; default terminal; only selected source commands.
// R2: Separate local and remote source settings; local/remote selection picks the active one.
// R3: Configured digital input selects: low means local, high means remote.
// R4: Without that input, a serial control bit selects; resets to 0, local.
// R5: Initial current accepts 50 to 600 percent; defaults to 100.
// R6: On start the current reference begins at the initial current.
// R7: Software must keep the initial current below the maximum current.
// R8: Maximum current accepts 100 to 800 percent; defaults to 600.
// R9: Maximum current is the reference reached at ramp end.
// R10: After the ramp the reference is capped at maximum current.
// R11: Ramp over before full speed: hold maximum until full speed or timer expiry.
// R12: Ramp runs initial to maximum over 0 to 300 s, default 15 s.
// R13: Out-of-range writes to source or current settings are ignored.
// R14: Ramp reference rises linearly with elapsed time.
`timescale 1ns/1ps
module start_source_current
    import start_ctrl_pkg::*;
#(
    parameter int MS_CYCLES = start_ctrl_pkg::CYC_PER_MS
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [start_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic keypadStart,
    input wire logic keypadStop,
    input wire logic termStart,
    input wire logic termStop,
    input wire logic locRemInputCfg,
    input wire logic locRemInput,
    input wire logic fullSpeed,
    output logic [start_ctrl_pkg::CUR_W-1:0] currentRef,
    output logic [start_ctrl_pkg::CUR_W-1:0] currentLimit,
    output logic motorRunning,
    output logic upToSpeedExpired
);
    import start_ctrl_pkg::*;

    // ======================================================
    // Parameter check
    initial begin
        if (MS_CYCLES < 1) begin
            $error("start_source_current: MS_CYCLES must be at least 1");
        end
    end

    // ======================================================
    // Settings and state
    logic [1:0] localSrc_r;
    logic [1:0] remoteSrc_r;
    logic [CUR_W-1:0] initCur_r;
    logic [CUR_W-1:0] maxCur_r;
    logic [SEC_W-1:0] rampTime_r;
    logic [SEC_W-1:0] utsTime_r;
    logic ctrlRemote_r;
    logic serStart_r;
    logic serStop_r;
    logic [31:0] prdata_r;
    logic [CUR_W-1:0] currentRef_r;
    logic [CUR_W-1:0] currentRef_nxt;
    logic [SEC_W-1:0] utsSec_r;
    logic utsExp_r;
    motor_state_t state_r;
    motor_state_t state_nxt;
    logic msTick;
    logic secTick;
    logic [CUR_W-1:0] rampLevel;
    logic rampDone;

    // ======================================================
    // APB decode
    wire regWrite = psel && penable && pwrite;
    wire setupRd = psel && !penable && !pwrite;
    wire addrHit = (paddr == OFS_LOCAL_SRC) || (paddr == OFS_REMOTE_SRC)
                || (paddr == OFS_INIT_CUR) || (paddr == OFS_MAX_CUR)
                || (paddr == OFS_RAMP_TIME) || (paddr == OFS_UTS_TIME)
                || (paddr == OFS_CONTROL) || (paddr == OFS_STATUS)
                || (paddr == OFS_CUR_REF);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrHit;

    // Write value checks
    // R13: range gates
    wire srcOk = in_range(16'(pwdata[15:0]), 16'(SRC_KEYPAD), 16'(SRC_SERIAL));
    wire initOk = in_range(pwdata[15:0], 16'(INIT_CUR_MIN), 16'(INIT_CUR_MAX))
               && (pwdata[31:16] == 16'h0000);
    wire maxOk = in_range(pwdata[15:0], 16'(MAX_CUR_MIN), 16'(MAX_CUR_MAX))
              && (pwdata[31:16] == 16'h0000);
    wire rampOk = in_range(pwdata[15:0], 16'h0000, 16'(RAMP_TIME_MAX))
               && (pwdata[31:16] == 16'h0000);
    wire utsOk = in_range(pwdata[15:0], 16'(UTS_TIME_MIN), 16'(UTS_TIME_MAX))
              && (pwdata[31:16] == 16'h0000);
    wire srcWordOk = srcOk && (pwdata[31:16] == 16'h0000);
    wire wrLocal = regWrite && (paddr == OFS_LOCAL_SRC) && srcWordOk;
    wire wrRemote = regWrite && (paddr == OFS_REMOTE_SRC) && srcWordOk;
    wire wrInit = regWrite && (paddr == OFS_INIT_CUR) && initOk;
    wire wrMax = regWrite && (paddr == OFS_MAX_CUR) && maxOk;
    wire wrRamp = regWrite && (paddr == OFS_RAMP_TIME) && rampOk;
    wire wrUts = regWrite && (paddr == OFS_UTS_TIME) && utsOk;
    wire wrCtrl = regWrite && (paddr == OFS_CONTROL);

    // Settings registers
    // R1: terminal default
    // R5: initial default
    // R8: maximum default
    // R12: ramp time default
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            localSrc_r <= SRC_RST;
            remoteSrc_r <= SRC_RST;
            initCur_r <= INIT_CUR_RST;
            maxCur_r <= MAX_CUR_RST;
            rampTime_r <= RAMP_TIME_RST;
            utsTime_r <= UTS_TIME_RST;
        end else begin
            if (wrLocal) localSrc_r <= pwdata[1:0];
            if (wrRemote) remoteSrc_r <= pwdata[1:0];
            if (wrInit) initCur_r <= pwdata[CUR_W-1:0];
            if (wrMax) maxCur_r <= pwdata[CUR_W-1:0];
            if (wrRamp) rampTime_r <= pwdata[SEC_W-1:0];
            if (wrUts) utsTime_r <= pwdata[SEC_W-1:0];
        end
    end

    // Control bit and serial start/stop pulses
    // R4: local after reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlRemote_r <= 1'b0;
            serStart_r <= 1'b0;
            serStop_r <= 1'b0;
        end else begin
            if (wrCtrl) ctrlRemote_r <= pwdata[CTRL_REMOTE_BIT];
            serStart_r <= wrCtrl && pwdata[CTRL_START_BIT];
            serStop_r <= wrCtrl && pwdata[CTRL_STOP_BIT];
        end
    end

    // ======================================================
    // Source selection
    // R3: input picks source
    // R4: serial bit picks source
    wire remoteSel = locRemInputCfg ? locRemInput : ctrlRemote_r;
    // R2: active source setting
    wire [1:0] activeSrc = remoteSel ? remoteSrc_r : localSrc_r;
    // R1: commands from selected source only
    wire selStart = (activeSrc == SRC_KEYPAD) ? keypadStart
                  : (activeSrc == SRC_TERMINAL) ? termStart
                  : (activeSrc == SRC_SERIAL) ? serStart_r : 1'b0;
    wire selStop = (activeSrc == SRC_KEYPAD) ? keypadStop
                 : (activeSrc == SRC_TERMINAL) ? termStop
                 : (activeSrc == SRC_SERIAL) ? serStop_r : 1'b0;
    wire startTake = (state_r == ST_IDLE) && selStart && !selStop;

    // ======================================================
    // Time bases and ramp
    tick_gen #(.DIV(MS_CYCLES)) msDiv (
        .clk(core_clk),
        .rstN(reset_n),
        .clr(startTake),
        .en(1'b1),
        .tick(msTick)
    );

    tick_gen #(.DIV(MS_PER_S)) secDiv (
        .clk(core_clk),
        .rstN(reset_n),
        .clr(startTake),
        .en(msTick),
        .tick(secTick)
    );

    // R12: ramp time in ms
    wire [MS_W-1:0] rampMs = MS_W'(rampTime_r * MS_PER_S);

    // R14: linear ramp generator
    ramp_gen #(.LVL_W(CUR_W), .MSW(MS_W)) ramp (
        .clk(core_clk),
        .rstN(reset_n),
        .load(startTake),
        .tick(msTick),
        .initLvl(initCur_r),
        .maxLvl(maxCur_r),
        .rampMs(rampMs),
        .level(rampLevel),
        .done(rampDone)
    );

    // Up-to-speed timer, seconds since start
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            utsSec_r <= '0;
            utsExp_r <= 1'b0;
        end else if (startTake) begin
            utsSec_r <= '0;
            utsExp_r <= 1'b0;
        end else if (secTick && !utsExp_r && state_r != ST_IDLE) begin
            utsSec_r <= utsSec_r + 1'b1;
            utsExp_r <= (utsSec_r + 1'b1) >= utsTime_r;
        end
    end

    // ======================================================
    // Start sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (startTake) state_nxt = ST_RAMP;
            end
            // R9: ramp ends at maximum
            ST_RAMP: begin
                if (rampDone) state_nxt = fullSpeed ? ST_RUN : ST_HOLD;
            end
            // R11: hold until speed or timer
            ST_HOLD: begin
                if (fullSpeed || utsExp_r) state_nxt = ST_RUN;
            end
            ST_RUN: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (selStop) state_nxt = ST_IDLE;
    end

    // Current reference per state
    // R6: ramp starts at initial
    // R10: capped at maximum
    always_comb begin
        case (state_r)
            ST_RAMP: currentRef_nxt = (rampLevel > maxCur_r) ? maxCur_r : rampLevel;
            ST_HOLD: currentRef_nxt = maxCur_r;
            ST_RUN: currentRef_nxt = maxCur_r;
            default: currentRef_nxt = '0;
        endcase
    end

    // Read data selection, unmapped reads zero
    wire [31:0] statusWord = (32'(state_r) << STAT_STATE_LSB)
                           | (32'(activeSrc) << STAT_SRC_LSB)
                           | (32'(remoteSel) << STAT_REMOTE_BIT)
                           | (32'(utsExp_r) << STAT_UTS_BIT);
    wire [31:0] readMux = (paddr == OFS_LOCAL_SRC) ? 32'(localSrc_r)
                        : (paddr == OFS_REMOTE_SRC) ? 32'(remoteSrc_r)
                        : (paddr == OFS_INIT_CUR) ? 32'(initCur_r)
                        : (paddr == OFS_MAX_CUR) ? 32'(maxCur_r)
                        : (paddr == OFS_RAMP_TIME) ? 32'(rampTime_r)
                        : (paddr == OFS_UTS_TIME) ? 32'(utsTime_r)
                        : (paddr == OFS_CONTROL) ? 32'(ctrlRemote_r)
                        : (paddr == OFS_STATUS) ? statusWord
                        : (paddr == OFS_CUR_REF) ? 32'(currentRef_r)
                        : 32'h0000_0000;

    // State and outputs
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            currentRef_r <= '0;
            prdata_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            currentRef_r <= currentRef_nxt;
            if (setupRd) prdata_r <= readMux;
        end
    end

    assign prdata = prdata_r;
    assign currentRef = currentRef_r;
    assign currentLimit = maxCur_r;
    assign motorRunning = (state_r != ST_IDLE);
    assign upToSpeedExpired = utsExp_r;

    // ======================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_din_select: assert property (locRemInputCfg |-> remoteSel == locRemInput) // R3
        else $error("digital input does not pick source");
    a_bit_select: assert property (!locRemInputCfg |-> remoteSel == ctrlRemote_r) // R4
        else $error("control bit does not pick source");
    a_src_route: assert property (activeSrc == (remoteSel ? remoteSrc_r : localSrc_r)) // R2
        else $error("active source is not the selected setting");
    a_foreign_start: assert property ((state_r == ST_IDLE && activeSrc == SRC_KEYPAD // R1
        && !keypadStart) |=> state_r == ST_IDLE)
        else $error("start taken from unselected source");
    a_ramp_first: assert property ((startTake && rampMs != '0) // R6
        |-> ##2 currentRef_r == $past(initCur_r, 2))
        else $error("ramp does not start at initial current");
    a_ramp_end: assert property ((state_r == ST_RAMP && rampDone && !selStop) // R9
        |=> state_r inside {ST_HOLD, ST_RUN})
        else $error("ramp does not end at its completion");
    a_hold_max: assert property (state_r == ST_HOLD |=> currentRef_r == $past(maxCur_r)) // R11
        else $error("hold level is not maximum current");
    a_run_cap: assert property (state_r == ST_RUN |=> currentRef_r == $past(maxCur_r)) // R10
        else $error("running reference not capped at maximum");
    a_ramp_mono: assert property ((state_r == ST_RAMP && $past(state_r) == ST_RAMP // R14
        && $stable(initCur_r)) |-> rampLevel >= $past(rampLevel))
        else $error("ramp reference decreased");
    a_reject_init: assert property ((regWrite && paddr == OFS_INIT_CUR && !initOk) // R13
        |=> $stable(initCur_r))
        else $error("out-of-range initial current stored");
    a_init_range: assert property (initCur_r >= INIT_CUR_MIN && initCur_r <= INIT_CUR_MAX) // R5
        else $error("initial current out of range");
    a_max_range: assert property (maxCur_r >= MAX_CUR_MIN && maxCur_r <= MAX_CUR_MAX) // R8
        else $error("maximum current out of range");
    a_ramp_range: assert property (rampTime_r <= RAMP_TIME_MAX) // R12
        else $error("ramp time out of range");

    c_start: cover property (startTake ##1 state_r == ST_RAMP);
    c_hold: cover property (state_r == ST_RAMP ##1 state_r == ST_HOLD);
    c_uts_run: cover property (state_r == ST_HOLD && utsExp_r ##1 state_r == ST_RUN);
    c_remote: cover property (remoteSel && startTake);
endmodule

// >>> test/start_partner.sv
// Operator-side model: keypad and terminal strip command lines.
// Assumes the bench calls press; lines change just after a rising edge.
`timescale 1ns/1ps
module start_partner (
    input wire logic clk,
    output logic keypadStart,
    output logic keypadStop,
    output logic termStart,
    output logic termStop
);
    logic [3:0] lines = 4'h0;
    // ==========================================
    // Command lines, order kpStart kpStop tStart tStop
    assign {keypadStart, keypadStop, termStart, termStop} = lines;
    // Hold the chosen lines for two edges, then release all
    task automatic press(input logic [3:0] m);
        @(posedge clk);
        lines <= m;
        repeat (2) @(posedge clk);
        lines <= 4'h0;
    endtask
endmodule

// >>> test/tb.sv
// Self-checking bench for the start source and current limit block.
// Assumes MS_CYCLES of 5, so one second of ramp is 5000 clocks.
`timescale 1ns/1ps
module tb;
    import start_ctrl_pkg::*;
    logic core_clk = 1'b0, reset_n, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, lastErr, kS, kP, tS, tP, motorRunning, upToSpeedExpired;
    logic locRemInputCfg, locRemInput, fullSpeed;
    logic [CUR_W-1:0] currentRef, currentLimit;
    int fails = 0, compares = 0;
    // ==========================================
    // Design and operator model
    start_source_current #(.MS_CYCLES(5)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .keypadStart(kS),
        .keypadStop(kP), .termStart(tS), .termStop(tP), .locRemInputCfg(locRemInputCfg),
        .locRemInput(locRemInput), .fullSpeed(fullSpeed), .currentRef(currentRef),
        .currentLimit(currentLimit), .motorRunning(motorRunning),
        .upToSpeedExpired(upToSpeedExpired));
    start_partner u_op (.clk(core_clk), .keypadStart(kS), .keypadStop(kP), .termStart(tS),
        .termStop(tP));
    // Clock of 20 ns
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    // ==========================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready, takes data at that edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1) fails++;
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0000_0000);
        check(rd, e);
    endtask
    task automatic waitRun(input logic e);
        int n;
        n = 0;
        while (motorRunning !== e && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        if (motorRunning !== e) fails++;
        #1;
    endtask
    // ==========================================
    // Scenarios
    task automatic testReset();
        rdChk(OFS_LOCAL_SRC, 32'h0000_0001);
        rdChk(OFS_REMOTE_SRC, 32'h0000_0001);
        rdChk(OFS_INIT_CUR, 32'h0000_0064);
        rdChk(OFS_MAX_CUR, 32'h0000_0258);
        rdChk(OFS_CONTROL, 32'h0000_0000);
        check(currentLimit, 32'h0000_0258);
    endtask
    task automatic testRange();
        apb(OFS_INIT_CUR, 1'b1, 32'h0000_0031);
        rdChk(OFS_INIT_CUR, 32'h0000_0064);
        apb(OFS_INIT_CUR, 1'b1, 32'h0000_0032);
        rdChk(OFS_INIT_CUR, 32'h0000_0032);
        apb(OFS_MAX_CUR, 1'b1, 32'h0000_0321);
        rdChk(OFS_MAX_CUR, 32'h0000_0258);
        apb(OFS_MAX_CUR, 1'b1, 32'h0000_0320);
        #1;
        check(currentLimit, 32'h0000_0320);
        apb(OFS_LOCAL_SRC, 1'b1, 32'h0000_0003);
        rdChk(OFS_LOCAL_SRC, 32'h0000_0001);
        rdChk(8'h40, 32'h0000_0000);
        check(lastErr, 1'b1);
        // Initial kept below maximum by software
        apb(OFS_INIT_CUR, 1'b1, 32'h0000_0064);
        apb(OFS_MAX_CUR, 1'b1, 32'h0000_00C8);
    endtask
    task automatic testSource();
        apb(OFS_LOCAL_SRC, 1'b1, 32'h0000_0000);
        u_op.press(4'h2);
        repeat (5) @(posedge core_clk);
        check(motorRunning, 1'b0);
        u_op.press(4'h8);
        waitRun(1'b1);
        @(posedge core_clk);
        #1;
        check(currentRef, 32'h0000_0064);
        u_op.press(4'h4);
        waitRun(1'b0);
        check(motorRunning, 1'b0);
    endtask
    task automatic testRemote();
        apb(OFS_CONTROL, 1'b1, 32'h0000_0001);
        rdChk(OFS_STATUS, 32'h0000_0110);
        locRemInputCfg <= 1'b1;
        rdChk(OFS_STATUS, 32'h0000_0000);
        locRemInput <= 1'b1;
        rdChk(OFS_STATUS, 32'h0000_0110);
    endtask
    task automatic testRamp();
        apb(OFS_RAMP_TIME, 1'b1, 32'h0000_0001);
        apb(OFS_UTS_TIME, 1'b1, 32'h0000_0002);
        u_op.press(4'h2);
        waitRun(1'b1);
        repeat (2500) @(posedge core_clk);
        #1;
        check(currentRef >= 10'd147 && currentRef <= 10'd153, 1'b1);
        repeat (2700) @(posedge core_clk);
        check(currentRef, 32'h0000_00C8);
        rdChk(OFS_STATUS, 32'h0000_0112);
        fullSpeed <= 1'b1;
        rdChk(OFS_STATUS, 32'h0000_0113);
        check(currentRef, 32'h0000_00C8);
        check(upToSpeedExpired, 1'b0);
        u_op.press(4'h1);
        waitRun(1'b0);
        check(currentRef, 32'h0000_0000);
    endtask
    // Serial source, zero ramp time, hold ended by timer expiry
    task automatic testExpire();
        fullSpeed <= 1'b0;
        apb(OFS_RAMP_TIME, 1'b1, 32'h0000_0000);
        apb(OFS_UTS_TIME, 1'b1, 32'h0000_0001);
        apb(OFS_REMOTE_SRC, 1'b1, 32'h0000_0002);
        u_op.press(4'h2);
        repeat (5) @(posedge core_clk);
        check(motorRunning, 1'b0);
        apb(OFS_CONTROL, 1'b1, 32'h0000_0002);
        waitRun(1'b1);
        @(posedge core_clk);
        #1;
        check(currentRef, 32'h0000_00C8);
        rdChk(OFS_STATUS, 32'h0000_0122);
        repeat (5100) @(posedge core_clk);
        #1;
        check(upToSpeedExpired, 1'b1);
        rdChk(OFS_STATUS, 32'h0000_0323);
        apb(OFS_CONTROL, 1'b1, 32'h0000_0004);
        waitRun(1'b0);
        check(motorRunning, 1'b0);
    endtask
    // ==========================================
    // Verdict and end of run
    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #(30_000 * 20);
        fails++;
        end_of_test();
    end
    // Main sequence
    initial begin
        reset_n <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0000_0000;
        locRemInputCfg <= 1'b0;
        locRemInput <= 1'b0;
        fullSpeed <= 1'b0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        testReset();
        testRange();
        testSource();
        testRemote();
        testRamp();
        testExpire();
        end_of_test();
    end
endmodule
